/* logic/seg_desc_cfg.svh */
`ifndef SEG_DESC_CFG_SVH
`define SEG_DESC_CFG_SVH

// ----------------------------------------
// upper-word field positions, and the half-word splits also used on the lower word
// ----------------------------------------
`define BIT_PRESENT 15
`define BIT_SYS_N 12
`define BIT_CODE 11
`define BIT_EXPDN 10
`define BIT_WRITE 9
`define BIT_ACC 8
`define BIT_SIZE 22
`define BIT_GRAN 23
`define DPL_HI 14
`define DPL_LO 13
`define TYPE_HI 11
`define TYPE_LO 8
`define PCNT_HI 4
`define PCNT_LO 0
`define LIM_HI_HI 19
`define LIM_HI_LO 16
`define HALF_HI 31
`define HALF_LO 16
`define LOW_HI 15
`define LOW_LO 0

// ----------------------------------------
// system type codes
// ----------------------------------------
`define SYS_TSS16_AVL 4'h1
`define SYS_LDT 4'h2
`define SYS_TSS16_BUSY 4'h3
`define SYS_CALL16 4'h4
`define SYS_TASK 4'h5
`define SYS_INT16 4'h6
`define SYS_TRAP16 4'h7
`define SYS_TSS32_AVL 4'h9
`define SYS_TSS32_BUSY 4'hB
`define SYS_CALL32 4'hC
`define SYS_INT32 4'hE
`define SYS_TRAP32 4'hF

// ----------------------------------------
// sizes, bounds and reset values
// ----------------------------------------
`define PARAM_BYTES_32 3'h4
`define PARAM_BYTES_16 3'h2
`define GRAN_SHIFT 12
`define MAX_OFS_32 32'hFFFFFFFF
`define MAX_OFS_16 32'h0000FFFF
`define RST_STACK_PTR 32'h00000000
`define RST_STACK_WIDE 1'h0

`endif

/* logic/seg_desc_pkg.sv */
`default_nettype none

package seg_desc_pkg;

  typedef enum logic [5:0] {
    REQ_LOAD_DATA  = 6'h01,
    REQ_LOAD_STACK = 6'h02,
    REQ_ACCESS     = 6'h04,
    REQ_GATE       = 6'h08,
    REQ_SYSTEM     = 6'h10,
    REQ_PUSH       = 6'h20
  } req_kind_e;

  typedef struct packed {
    logic        done;
    logic        gp;
    logic        np;
    logic        writeback;
    logic [31:0] desc_hi;
    logic [1:0]  descriptor_privilege_level;
    logic        is_data;
    logic        is_gate;
    logic        is_task_gate;
    logic        is_tss;
    logic        is_ldt;
    logic        tss_busy;
    logic        wide;
    logic [31:0] ip;
    logic [15:0] code_sel;
    logic [15:0] task_sel;
    logic [4:0]  param_count;
    logic [2:0]  param_bytes;
    logic        stack_wide;
    logic [31:0] stack_ptr;
  } state_s;

endpackage

`default_nettype wire

/* logic/limit_check.sv */
`include "seg_desc_cfg.svh"
`default_nettype none

// byte range test of one reference against a data segment
module limit_check (
  input  wire logic [19:0] limit_i,
  input  wire logic        gran_i,
  input  wire logic        expdn_i,
  input  wire logic        big_i,
  input  wire logic [31:0] offset_i,
  input  wire logic [2:0]  size_i,
  output logic             in_range_o
);

  logic [31:0] lim;
  logic [31:0] upper;
  logic [32:0] last;
  logic [2:0]  eff;

  always_comb begin
    lim = gran_i ? {limit_i, {`GRAN_SHIFT{1'b1}}}
                 : {12'h000, limit_i};
    upper = big_i ? `MAX_OFS_32 : `MAX_OFS_16;
    eff = (size_i == 3'h0) ? 3'h1 : size_i;
    // last byte touched; carry out means wrap past 4G
    last = {1'b0, offset_i} + {30'h0, eff} - 33'h1;
    if (expdn_i) begin
      in_range_o = (offset_i > lim) && !last[32]
                   && (last[31:0] <= upper);
    end else begin
      in_range_o = !last[32] && (last[31:0] <= lim);
    end
  end

endmodule

`default_nettype wire

/* logic/legacy_segment_descriptor_decode.sv */
`include "seg_desc_cfg.svh"
`default_nettype none

module legacy_segment_descriptor_decode (
  input  wire logic                   clock_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   req_valid_i,
  input  wire seg_desc_pkg::req_kind_e req_kind_i,
  input  wire logic [31:0]            desc_lo_i,
  input  wire logic [31:0]            desc_hi_i,
  input  wire logic [31:0]            offset_i,
  input  wire logic [2:0]             access_size_i,
  input  wire logic                   access_write_i,
  input  wire logic [31:0]            stack_ptr_i,
  input  wire logic [2:0]             push_size_i,
  output logic                        done_o,
  output logic                        general_protection_fault_o,
  output logic                        segment_not_present_fault_o,
  output logic                        writeback_o,
  output logic [31:0]                 desc_hi_o,
  output logic [1:0]                  descriptor_privilege_level_o,
  output logic                        is_data_o,
  output logic                        is_gate_o,
  output logic                        is_task_gate_o,
  output logic                        is_task_state_segment_o,
  output logic                        is_local_descriptor_table_o,
  output logic                        task_state_busy_o,
  output logic                        wide_o,
  output logic [31:0]                 instruction_pointer_o,
  output logic [15:0]                 code_sel_o,
  output logic [15:0]                 task_sel_o,
  output logic [4:0]                  param_count_o,
  output logic [2:0]                  param_bytes_o,
  output logic                        stack_wide_o,
  output logic [31:0]                 stack_ptr_o
);

  // ----------------------------------------
  // descriptor fields
  // ----------------------------------------
  logic        present;
  logic        user_seg;
  logic        data_seg;
  logic        writable;
  logic        size_bit;
  logic [3:0]  sys_type;
  logic [1:0]  descriptor_privilege_level;
  logic [19:0] limit;
  logic        in_range;

  assign present  = desc_hi_i[`BIT_PRESENT];
  assign user_seg = desc_hi_i[`BIT_SYS_N];
  assign data_seg = user_seg && !desc_hi_i[`BIT_CODE];
  assign writable = desc_hi_i[`BIT_WRITE];
  assign size_bit = desc_hi_i[`BIT_SIZE];
  assign sys_type = desc_hi_i[`TYPE_HI:`TYPE_LO];
  assign descriptor_privilege_level      = desc_hi_i[`DPL_HI:`DPL_LO];
  assign limit    = {desc_hi_i[`LIM_HI_HI:`LIM_HI_LO],
                     desc_lo_i[`LOW_HI:`LOW_LO]};

  // ----------------------------------------
  // offset range against the segment
  // ----------------------------------------
  limit_check u_limit_check (
    .limit_i    (limit),
    .gran_i     (desc_hi_i[`BIT_GRAN]),
    .expdn_i    (desc_hi_i[`BIT_EXPDN]),
    .big_i      (size_bit),
    .offset_i   (offset_i),
    .size_i     (access_size_i),
    .in_range_o (in_range)
  );

  // ----------------------------------------
  // system type classification
  // ----------------------------------------
  logic sys_legal;
  logic sys_gate;
  logic sys_call;
  logic sys_task;
  logic sys_tss;
  logic sys_ldt;
  logic sys_busy;
  logic sys_wide;

  always_comb begin
    sys_legal = 1'b1;
    sys_gate  = 1'b0;
    sys_call  = 1'b0;
    sys_task  = 1'b0;
    sys_tss   = 1'b0;
    sys_ldt   = 1'b0;
    sys_busy  = 1'b0;
    sys_wide  = 1'b0;
    case (sys_type)
      `SYS_TSS16_AVL: begin
        sys_tss = 1'b1;
      end
      `SYS_LDT: begin
        sys_ldt = 1'b1;
      end
      `SYS_TSS16_BUSY: begin
        sys_tss  = 1'b1;
        sys_busy = 1'b1;
      end
      `SYS_TSS32_AVL: begin
        sys_tss  = 1'b1;
        sys_wide = 1'b1;
      end
      `SYS_TSS32_BUSY: begin
        sys_tss  = 1'b1;
        sys_busy = 1'b1;
        sys_wide = 1'b1;
      end
      `SYS_CALL16: begin
        sys_gate = 1'b1;
        sys_call = 1'b1;
      end
      `SYS_CALL32: begin
        sys_gate = 1'b1;
        sys_call = 1'b1;
        sys_wide = 1'b1;
      end
      `SYS_TASK: begin
        sys_gate = 1'b1;
        sys_task = 1'b1;
      end
      `SYS_INT16,
      `SYS_TRAP16: begin
        sys_gate = 1'b1;
      end
      `SYS_INT32,
      `SYS_TRAP32: begin
        sys_gate = 1'b1;
        sys_wide = 1'b1;
      end
      default: begin
        // codes 0, 8, A and D
        sys_legal = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  seg_desc_pkg::state_s state;
  seg_desc_pkg::state_s next_state;

  always_comb begin
    next_state = state;
    next_state.done      = 1'b0;
    next_state.gp        = 1'b0;
    next_state.np        = 1'b0;
    next_state.writeback = 1'b0;
    if (req_valid_i) begin
      next_state.done         = 1'b1;
      next_state.desc_hi      = desc_hi_i;
      next_state.descriptor_privilege_level          = descriptor_privilege_level;
      next_state.is_data      = data_seg;
      next_state.is_gate      = !user_seg && sys_legal && sys_gate;
      next_state.is_task_gate = !user_seg && sys_legal && sys_task;
      next_state.is_tss       = !user_seg && sys_tss;
      next_state.is_ldt       = !user_seg && sys_ldt;
      next_state.tss_busy     = !user_seg && sys_busy;
      next_state.wide         = user_seg ? size_bit : sys_wide;
      unique case (req_kind_i)
        seg_desc_pkg::REQ_LOAD_DATA: begin
          // present bit is only read, never written back changed
          if (!present) begin
            next_state.np = 1'b1;
          end else if (!data_seg) begin
            next_state.gp = 1'b1;
          end else begin
            // A only ever goes to 1 here
            next_state.desc_hi[`BIT_ACC] = 1'b1;
            next_state.writeback = !desc_hi_i[`BIT_ACC];
          end
        end
        seg_desc_pkg::REQ_LOAD_STACK: begin
          if (!data_seg || !writable) begin
            next_state.gp = 1'b1;
          end else if (!present) begin
            next_state.np = 1'b1;
          end else begin
            next_state.desc_hi[`BIT_ACC] = 1'b1;
            next_state.writeback = !desc_hi_i[`BIT_ACC];
            next_state.stack_wide = size_bit;
          end
        end
        seg_desc_pkg::REQ_ACCESS: begin
          if (!present) begin
            next_state.np = 1'b1;
          end else if (!data_seg) begin
            next_state.gp = 1'b1;
          end else if (access_write_i && !writable) begin
            next_state.gp = 1'b1;
          end else if (!in_range) begin
            next_state.gp = 1'b1;
          end
        end
        seg_desc_pkg::REQ_GATE: begin
          // type checked before presence: a non-gate is never a gate
          if (user_seg || !sys_legal || !sys_gate) begin
            next_state.gp = 1'b1;
          end else if (!present) begin
            next_state.np = 1'b1;
          end else if (sys_task) begin
            // offset halves and parameter count field are not used
            next_state.task_sel =
              desc_lo_i[`HALF_HI:`HALF_LO];
          end else begin
            // of the low byte of the upper word only bits 4:0 are read, for call gates
            next_state.ip = {desc_hi_i[`HALF_HI:`HALF_LO],
                             desc_lo_i[`LOW_HI:`LOW_LO]};
            next_state.code_sel =
              desc_lo_i[`HALF_HI:`HALF_LO];
            if (sys_call) begin
              next_state.param_count =
                desc_hi_i[`PCNT_HI:`PCNT_LO];
              next_state.param_bytes = sys_wide
                ? `PARAM_BYTES_32 : `PARAM_BYTES_16;
            end else begin
              next_state.param_count = 5'h00;
              next_state.param_bytes = 3'h0;
            end
          end
        end
        seg_desc_pkg::REQ_SYSTEM: begin
          if (user_seg || !sys_legal || sys_gate) begin
            next_state.gp = 1'b1;
          end else if (!present) begin
            next_state.np = 1'b1;
          end
        end
        seg_desc_pkg::REQ_PUSH: begin
          // narrow stack wraps in 64K; upper half is left alone
          if (state.stack_wide) begin
            next_state.stack_ptr =
              stack_ptr_i - {29'h0, push_size_i};
          end else begin
            next_state.stack_ptr = {stack_ptr_i[`HALF_HI:`HALF_LO],
              stack_ptr_i[`LOW_HI:`LOW_LO]
              - {13'h0, push_size_i}};
          end
        end
        default: begin
          // not a one-hot request code
          next_state.gp = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state <= '0;
      state.stack_wide <= `RST_STACK_WIDE;
      state.stack_ptr  <= `RST_STACK_PTR;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // outputs, all from the state register
  // ----------------------------------------
  assign done_o                       = state.done;
  assign general_protection_fault_o   = state.gp;
  assign segment_not_present_fault_o  = state.np;
  assign writeback_o                  = state.writeback;
  assign desc_hi_o                    = state.desc_hi;
  assign descriptor_privilege_level_o = state.descriptor_privilege_level;
  assign is_data_o                    = state.is_data;
  assign is_gate_o                    = state.is_gate;
  assign is_task_gate_o               = state.is_task_gate;
  assign is_task_state_segment_o      = state.is_tss;
  assign is_local_descriptor_table_o  = state.is_ldt;
  assign task_state_busy_o            = state.tss_busy;
  assign wide_o                       = state.wide;
  assign instruction_pointer_o        = state.ip;
  assign code_sel_o                   = state.code_sel;
  assign task_sel_o                   = state.task_sel;
  assign param_count_o                = state.param_count;
  assign param_bytes_o                = state.param_bytes;
  assign stack_wide_o                 = state.stack_wide;
  assign stack_ptr_o                  = state.stack_ptr;

endmodule

`default_nettype wire

/* logic/_unused_guard.sv */
`default_nettype none
`default_nettype wire

/* bench/seg_desc_checker_asserts.sv */
`default_nettype none

module seg_desc_checker (
  input wire logic                    clock_i,
  input wire logic                    rst_n_i,
  input wire logic                    req_valid_i,
  input wire seg_desc_pkg::req_kind_e req_kind_i,
  input wire logic [31:0]             desc_lo_i,
  input wire logic [31:0]             desc_hi_i,
  input wire logic                    done_o,
  input wire logic                    general_protection_fault_o,
  input wire logic                    segment_not_present_fault_o,
  input wire logic [31:0]             desc_hi_o,
  input wire logic                    is_task_gate_o,
  input wire logic [31:0]             instruction_pointer_o,
  input wire logic [15:0]             code_sel_o,
  input wire logic [15:0]             task_sel_o,
  input wire logic [4:0]              param_count_o,
  input wire logic [2:0]              param_bytes_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_req(k);
    req_valid_i && req_kind_i == k;
  endsequence
  sequence s_ok;
    done_o && !general_protection_fault_o && !segment_not_present_fault_o;
  endsequence

  a_answer_next: assert property ($past(req_valid_i) |-> done_o)
    else $error("no answer one cycle after a request");
  a_stray_done: assert property (done_o |-> $past(req_valid_i))
    else $error("answer without a request");
  a_fault_framed: assert property ((general_protection_fault_o || segment_not_present_fault_o)
    |-> done_o)
    else $error("fault pulse outside an answer");
  a_acc_set: assert property (s_req(seg_desc_pkg::REQ_LOAD_DATA) ##1 s_ok |-> desc_hi_o[8])
    else $error("accessed bit not set on load");
  a_acc_kept: assert property (req_valid_i && desc_hi_i[8] ##1 done_o |-> desc_hi_o[8])
    else $error("accessed bit cleared");
  a_present_kept: assert property (done_o |-> desc_hi_o[15] == $past(desc_hi_i[15]))
    else $error("present bit altered");
  a_absent_np: assert property (s_req(seg_desc_pkg::REQ_LOAD_DATA) ##0 !desc_hi_i[15]
    |=> segment_not_present_fault_o)
    else $error("absent segment loaded without fault");
  a_reserved_gp: assert property (s_req(seg_desc_pkg::REQ_SYSTEM)
    ##0 (desc_hi_i[11:8] inside {4'h0, 4'h8, 4'hA, 4'hD}) |=> general_protection_fault_o)
    else $error("reserved system type accepted");
  a_gate_target: assert property (s_req(seg_desc_pkg::REQ_GATE) ##1 (s_ok ##0 !is_task_gate_o)
    |-> instruction_pointer_o == {$past(desc_hi_i[31:16]), $past(desc_lo_i[15:0])}
    && code_sel_o == $past(desc_lo_i[31:16]))
    else $error("gate target wrong");
  a_task_sel: assert property (s_req(seg_desc_pkg::REQ_GATE) ##1 (s_ok ##0 is_task_gate_o)
    |-> task_sel_o == $past(desc_lo_i[31:16]))
    else $error("task gate selector wrong");
  a_param_count: assert property (s_req(seg_desc_pkg::REQ_GATE) ##0 desc_hi_i[11:8] == 4'hC
    ##1 s_ok |-> param_count_o == $past(desc_hi_i[4:0]) && param_bytes_o == 3'h4)
    else $error("call gate parameter count wrong");
endmodule

bind legacy_segment_descriptor_decode seg_desc_checker chk (.*);

`default_nettype wire

/* bench/desc_table.sv */
`default_nettype none

// descriptor slots as system software leaves them in memory
module desc_table (
  input  wire logic        clock_i,
  input  wire logic        wr_i,
  input  wire logic [1:0]  slot_i,
  input  wire logic [63:0] word_i,
  output logic      [31:0] lo_o,
  output logic      [31:0] hi_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] mem [4];

  // entries are always written before the block is asked to use them
  always @(posedge clock_i) if (wr_i) mem[slot_i] <= word_i;
  assign {hi_o, lo_o} = mem[slot_i];
endmodule

`default_nettype wire

/* bench/test_legacy_segment_descriptor_decode.sv */
`default_nettype none

module test_legacy_segment_descriptor_decode;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_i = 1'b0, rst_n_i, req_valid_i, access_write_i, wr, sw, ok;
  seg_desc_pkg::req_kind_e req_kind_i;
  logic [31:0] desc_lo_i, desc_hi_i, offset_i, stack_ptr_i, seed, h, l, r, instruction_pointer;
  logic [2:0]  access_size_i, push_size_i, param_bytes_o;
  logic        done_o, general_protection_fault_o, segment_not_present_fault_o, writeback_o;
  logic        is_data_o, is_gate_o, is_task_gate_o, is_task_state_segment_o, wide_o;
  logic        is_local_descriptor_table_o, task_state_busy_o, stack_wide_o;
  logic [31:0] desc_hi_o, instruction_pointer_o, stack_ptr_o;
  logic [15:0] code_sel_o, task_sel_o;
  logic [4:0]  param_count_o;
  logic [3:0]  c;
  logic [3:0]  gates [7] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'hC, 4'hE, 4'hF};
  logic [1:0]  descriptor_privilege_level_o, slot;
  logic [63:0] word;
  int          miscompares, compares, cycles, i;

  legacy_segment_descriptor_decode uut (.*);
  desc_table mem (.clock_i(clock_i), .wr_i(wr), .slot_i(slot), .word_i(word),
    .lo_o(desc_lo_i), .hi_o(desc_hi_i));

  always #20 clock_i = ~clock_i;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] rand32();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  function automatic logic [31:0] lim_of(input logic [31:0] lo, hi);
    return hi[23] ? {hi[19:16], lo[15:0], 12'hFFF} : {12'h000, hi[19:16], lo[15:0]};
  endfunction

  function automatic logic gp_exp(input logic [31:0] lo, hi, o, input logic [2:0] z,
    input logic w);
    logic [31:0] lim, up;
    logic [32:0] last;
    lim = lim_of(lo, hi);
    up = hi[10] ? (hi[22] ? 32'hFFFFFFFF : 32'h0000FFFF) : lim;
    last = {1'b0, o} + {30'h0, (z == 3'h0 ? 3'h1 : z)} - 33'h1;
    return (w && !hi[9]) || (hi[10] && o <= lim) || last > {1'b0, up};
  endfunction

  function automatic logic [31:0] psp(input logic [31:0] sp, input logic [2:0] z,
    input logic wd);
    return wd ? sp - {29'h0, z} : {sp[31:16], sp[15:0] - {13'h0, z}};
  endfunction

  task automatic chk(input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  // slot rotates so a stale descriptor never masquerades as the new one
  task automatic req(input seg_desc_pkg::req_kind_e k, input logic [31:0] lo, hi);
    @(negedge clock_i);
    wr = 1'b1;
    slot = slot + 2'h1;
    word = {hi, lo};
    @(negedge clock_i);
    wr = 1'b0;
    req_valid_i = 1'b1;
    req_kind_i = k;
    @(negedge clock_i);
    req_valid_i = 1'b0;
  endtask

  task automatic finish_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      finish_test();
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    {rst_n_i, req_valid_i, access_write_i, wr, slot, offset_i, stack_ptr_i, word} = '0;
    {access_size_i, push_size_i} = '0;
    req_kind_i = seg_desc_pkg::REQ_LOAD_DATA;
    seed = 32'h68A1D68D;
    instruction_pointer = 32'h0;
    sw = 1'b0;
    repeat (5) @(negedge clock_i);
    rst_n_i = 1'b1;
    for (i = 0; i < 16; i++) begin
      h = rand32();
      h[15] = i % 5 != 1;
      h[12] = 1'b1;
      h[11] = i == 15;
      req(seg_desc_pkg::REQ_LOAD_DATA, rand32(), h);
      chk(segment_not_present_fault_o, !h[15]);
      chk(general_protection_fault_o, h[15] & h[11]);
      chk(writeback_o, h[15] & !h[11] & !h[8]);
      chk(desc_hi_o[15], h[15]);
      if (h[15] && !h[11]) chk(desc_hi_o, h | 32'h00000100);
      if (h[15] && !h[11]) chk(is_data_o, 1'b1);
    end
    for (i = 0; i < 4; i++) begin
      h = rand32() | 32'h00009000;
      h[11] = 1'b0;
      h[9] = i[0];
      h[22] = i[1];
      req(seg_desc_pkg::REQ_LOAD_STACK, rand32(), h);
      sw = i[0] ? i[1] : sw;
      chk(general_protection_fault_o, !i[0]);
      chk(stack_wide_o, sw);
      stack_ptr_i = rand32();
      if (i == 1) stack_ptr_i[15:0] = 16'h0001;
      push_size_i = i[1] ? 3'h4 : 3'h2;
      req(seg_desc_pkg::REQ_PUSH, rand32(), h);
      chk(stack_ptr_o, psp(stack_ptr_i, push_size_i, sw));
    end
    for (i = 0; i < 40; i++) begin
      h = rand32() | 32'h00009000;
      h[11] = 1'b0;
      if (i % 4 == 2) h[23:16] = 8'h00;
      if (i % 4 == 2) h[10] = 1'b1;
      l = rand32();
      r = rand32();
      offset_i = i[0] ? lim_of(l, h) + {29'h0, r[2:0]} - 32'h2 : 32'hFFFD + {29'h0, r[2:0]};
      access_size_i = 3'h1 << r[4:3];
      access_write_i = r[5];
      req(seg_desc_pkg::REQ_ACCESS, l, h);
      chk(general_protection_fault_o,
        gp_exp(l, h, offset_i, access_size_i, access_write_i));
    end
    for (i = 0; i < 8; i++) begin
      c = gates[i % 7];
      h = rand32();
      h[15] = i < 7;
      h[12] = 1'b0;
      h[11:8] = c;
      l = rand32();
      req(seg_desc_pkg::REQ_GATE, l, h);
      chk(segment_not_present_fault_o, !h[15]);
      if (h[15]) begin
        chk(is_gate_o, 1'b1);
        chk(is_task_gate_o, c == 4'h5);
        chk(descriptor_privilege_level_o, h[14:13]);
        if (c == 4'h5) begin
          chk(task_sel_o, l[31:16]);
          chk(instruction_pointer_o, instruction_pointer);
        end else begin
          instruction_pointer = {h[31:16], l[15:0]};
          chk(instruction_pointer_o, instruction_pointer);
          chk(code_sel_o, l[31:16]);
          chk(param_count_o, c[2:0] == 3'h4 ? h[4:0] : 5'h0);
          chk(param_bytes_o, c == 4'hC ? 3'h4 : (c == 4'h4 ? 3'h2 : 3'h0));
          chk(wide_o, c[3]);
        end
      end
    end
    for (i = 0; i < 16; i++) begin
      c = i[3:0];
      h = rand32() | 32'h00008000;
      h[12] = 1'b0;
      h[11:8] = c;
      req(seg_desc_pkg::REQ_SYSTEM, rand32(), h);
      ok = c inside {4'h1, 4'h2, 4'h3, 4'h9, 4'hB};
      chk(general_protection_fault_o, !ok);
      if (ok) begin
        chk(is_task_state_segment_o, c != 4'h2);
        chk(is_local_descriptor_table_o, c == 4'h2);
        chk(task_state_busy_o, c[1:0] == 2'h3);
        chk(wide_o, c[3]);
      end
    end
    req(seg_desc_pkg::REQ_SYSTEM, rand32(), 32'h00000900);
    chk(segment_not_present_fault_o, 1'b1);
    chk(general_protection_fault_o, 1'b0);
    req(seg_desc_pkg::req_kind_e'(6'h03), rand32(), 32'h00009200);
    chk(general_protection_fault_o, 1'b1);
    finish_test();
  end
endmodule

`default_nettype wire
